// *** rtl/ccsp_device.sv ***
// Our own choice: register access over APB.
module ccsp_device
  import ccsp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  ccsp_if.device link,
  output logic o_serial_mode,
  output logic o_powerdown,
  output logic o_standby,
  output logic o_stabilizer_en,
  output logic [1:0] o_format_sel,
  output logic o_clock_invert,
  output logic [3:0] o_phase_adj,
  output logic [3:0] o_test_mode
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_INSTR = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } ccsp_dev_e;

  // ==========================================================
  // pin synchronisers
  logic [2:0] cs_s;
  logic [2:0] ck_s;
  logic [1:0] io_s;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      cs_s <= 3'h7;
      ck_s <= 3'h0;
      io_s <= 2'h3;
    end else begin
      cs_s <= {cs_s[1:0], link.port_select_n};
      ck_s <= {ck_s[1:0], link.shift_clock_format_pin};
      io_s <= {io_s[0], link.serial_io_stabilizer_pin};
    end
  end

  logic sel;
  logic rise;
  logic din;
  assign sel = ~cs_s[1];
  assign rise = ck_s[1] & ~ck_s[2];
  assign din = io_s[1];

  // ==========================================================
  // registers
  logic lsb_first;
  logic [7:0] modes;
  logic [7:0] clock_reg;
  logic [7:0] test_io;
  logic [7:0] out_mode;
  logic [7:0] phase;

  function automatic logic [7:0] rd_reg(input logic [12:0] a, input logic l, input logic [7:0] m,
      input logic [7:0] c, input logic [7:0] t, input logic [7:0] o, input logic [7:0] p);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      OFS_CFG: v = {1'b0, l, 1'b0, 2'h3, 1'b0, l, 1'b0};
      OFS_ID: v = CHIP_ID_VAL;
      OFS_GRADE: v = GRADE_VAL;
      OFS_MODES: v = m;
      OFS_CLOCK: v = c;
      OFS_TEST: v = t;
      OFS_OUTMODE: v = o;
      OFS_PHASE: v = p;
      default: v = 8'h00;
    endcase
    return v;
  endfunction : rd_reg

  // ==========================================================
  // frame engine
  ccsp_dev_e state;
  logic [3:0] bit_cnt;
  logic [14:0] instr;
  logic [12:0] addr;
  logic is_rd;
  logic [1:0] len;
  logic [1:0] left;
  logic [7:0] rx;
  logic [7:0] tx;
  logic [7:0] next_rx;
  logic [15:0] next_instr;
  logic byte_end;
  logic wr_en;
  logic [7:0] cur_rd;
  logic [7:0] nxt_rd;

  assign next_rx = lsb_first ? {din, rx[7:1]} : {rx[6:0], din};
  assign next_instr = {instr, din};
  assign byte_end = sel & rise & (state == ST_DATA) & (bit_cnt == 4'h7);
  assign wr_en = byte_end & ~is_rd;
  assign cur_rd = rd_reg(next_instr[12:0], lsb_first, modes, clock_reg, test_io, out_mode, phase);
  assign nxt_rd = rd_reg(addr + 13'h0001, lsb_first, modes, clock_reg, test_io, out_mode, phase);

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      instr <= 15'h0000;
      addr <= 13'h0000;
      is_rd <= 1'b0;
      len <= 2'h0;
      left <= 2'h0;
      rx <= 8'h00;
      tx <= 8'h00;
    end else if (!sel) begin
      unique case (state)
        ST_INSTR: state <= ST_IDLE;
        ST_DATA: begin
          if (bit_cnt != 4'h0 || len == LEN_STREAM) begin
            state <= ST_IDLE;
          end
        end
        ST_DONE: state <= ST_IDLE;
        ST_IDLE: state <= ST_IDLE;
      endcase
      bit_cnt <= (state == ST_DATA) ? bit_cnt : 4'h0;
    end else if (rise) begin
      unique case (state)
        ST_IDLE: begin
          instr <= {14'h0000, din};
          bit_cnt <= 4'h1;
          state <= ST_INSTR;
        end
        ST_INSTR: begin
          instr <= next_instr[14:0];
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'hf) begin
            is_rd <= next_instr[RW_POS];
            len <= next_instr[LEN_HI:LEN_LO];
            left <= next_instr[LEN_HI:LEN_LO];
            addr <= next_instr[ADDR_BITS-1:0];
            tx <= cur_rd;
            bit_cnt <= 4'h0;
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          rx <= next_rx;
          tx <= lsb_first ? {1'b0, tx[7:1]} : {tx[6:0], 1'b0};
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'h7) begin
            bit_cnt <= 4'h0;
            addr <= addr + 13'h0001;
            tx <= nxt_rd;
            if (len != LEN_STREAM) begin
              left <= left - 2'h1;
              if (left == 2'h0) begin
                state <= ST_DONE;
              end
            end
          end
        end
        ST_DONE: state <= ST_DONE;
      endcase
    end
  end

  // ==========================================================
  // data pin turnaround
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      link.dev_sdio_o <= 1'b0;
      link.dev_sdio_oe <= 1'b0;
    end else begin
      link.dev_sdio_o <= lsb_first ? tx[0] : tx[7];
      link.dev_sdio_oe <= sel & is_rd & (state == ST_DATA);
    end
  end

  // ==========================================================
  // register writes
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || (wr_en && addr == OFS_CFG && (next_rx[CFG_SOFT_HI] | next_rx[CFG_SOFT_LO]))) begin
      lsb_first <= RST_CFG[CFG_LSB_HI];
      modes <= RST_MODES;
      clock_reg <= RST_CLOCK;
      test_io <= RST_TEST;
      out_mode <= RST_OUTMODE;
      phase <= RST_PHASE;
    end else if (wr_en) begin
      unique case (addr)
        OFS_CFG: lsb_first <= next_rx[CFG_LSB_HI] | next_rx[CFG_LSB_LO];
        OFS_MODES: modes <= next_rx;
        OFS_CLOCK: clock_reg <= next_rx;
        OFS_TEST: test_io <= next_rx;
        OFS_OUTMODE: out_mode <= next_rx;
        OFS_PHASE: phase <= next_rx;
        default: lsb_first <= lsb_first;
      endcase
    end
  end

  // ==========================================================
  // strap mode and static outputs
  logic strap_mode;
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      strap_mode <= 1'b1;
    end else if (sel) begin
      strap_mode <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_serial_mode <= 1'b0;
      o_powerdown <= 1'b0;
      o_standby <= 1'b0;
      o_stabilizer_en <= RST_CLOCK[0];
      o_format_sel <= 2'h0;
      o_clock_invert <= 1'b0;
      o_phase_adj <= 4'h0;
      o_test_mode <= 4'h0;
    end else begin
      o_serial_mode <= ~strap_mode;
      o_stabilizer_en <= strap_mode ? din : clock_reg[0];
      o_format_sel <= strap_mode ? {1'b0, ck_s[1]} : out_mode[1:0];
      o_powerdown <= modes[2:0] == MODE_PDWN;
      o_standby <= modes[2:0] == MODE_STBY;
      o_clock_invert <= phase[PHASE_POL];
      o_phase_adj <= phase[3:0];
      o_test_mode <= test_io[3:0];
    end
  end
endmodule : ccsp_device

// *** rtl/ccsp_pkg.sv ***
package ccsp_pkg;
  localparam int INSTR_BITS = 16;
  localparam int ADDR_BITS = 13;
  localparam int RW_POS = 15;
  localparam int LEN_HI = 14;
  localparam int LEN_LO = 13;
  localparam logic [1:0] LEN_STREAM = 2'h3;
  // device register map
  localparam logic [12:0] OFS_CFG = 13'h0000;
  localparam logic [12:0] OFS_ID = 13'h0001;
  localparam logic [12:0] OFS_GRADE = 13'h0002;
  localparam logic [12:0] OFS_MODES = 13'h0008;
  localparam logic [12:0] OFS_CLOCK = 13'h0009;
  localparam logic [12:0] OFS_TEST = 13'h000d;
  localparam logic [12:0] OFS_OUTMODE = 13'h000e;
  localparam logic [12:0] OFS_PHASE = 13'h0014;
  localparam logic [12:0] OFS_UPDATE = 13'h00ff;
  localparam int CFG_LSB_HI = 6;
  localparam int CFG_LSB_LO = 1;
  localparam int CFG_SOFT_HI = 5;
  localparam int CFG_SOFT_LO = 2;
  localparam logic [7:0] RST_CFG = 8'h18;
  localparam logic [7:0] RST_MODES = 8'h00;
  localparam logic [7:0] RST_CLOCK = 8'h01;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_OUTMODE = 8'h00;
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [2:0] MODE_PDWN = 3'h1;
  localparam logic [2:0] MODE_STBY = 3'h2;
  localparam int PHASE_POL = 7;
  // arbitrary identity values
  localparam logic [7:0] CHIP_ID_VAL = 8'h5a;
  localparam logic [7:0] GRADE_VAL = 8'h00;
  // host register map (apb)
  localparam logic [7:0] H_CTRL = 8'h00;
  localparam logic [7:0] H_ADDR = 8'h04;
  localparam logic [7:0] H_WDATA = 8'h08;
  localparam logic [7:0] H_RDATA = 8'h0c;
  localparam logic [7:0] H_STATUS = 8'h10;
  localparam int C_GO = 0;
  localparam int C_RD = 1;
  localparam int C_LEN = 2;
  localparam int C_STRAP = 4;
  localparam int C_FMT = 5;
  localparam int C_DCS = 6;
  localparam int C_PAUSE = 7;
  localparam int C_LSB = 8;
  localparam logic [8:0] RST_CTRL = 9'h000;
  // timing
  localparam int CLK_NS = 10;
  localparam int HALF_NS = 80;
  localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;
endpackage : ccsp_pkg

// *** rtl/ccsp_if.sv ***
interface ccsp_if;
  logic port_select_n;
  logic shift_clock_format_pin;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic serial_io_stabilizer_pin;
  // wire level from enables, pulled high when nobody drives
  assign serial_io_stabilizer_pin = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b1);
  modport device (
    input port_select_n,
    input shift_clock_format_pin,
    input serial_io_stabilizer_pin,
    output dev_sdio_o,
    output dev_sdio_oe
  );
  modport host (
    output port_select_n,
    output shift_clock_format_pin,
    output host_sdio_o,
    output host_sdio_oe,
    input serial_io_stabilizer_pin
  );
endinterface : ccsp_if

// *** rtl/ccsp_host.sv ***
module ccsp_host
  import ccsp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  ccsp_if.host link,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001,
    HS_LOW = 5'b00010,
    HS_HIGH = 5'b00100,
    HS_GAP = 5'b01000,
    HS_END = 5'b10000
  } ccsp_host_e;

  // ==========================================================
  // apb slave
  logic [8:0] ctrl;
  logic [12:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic busy;
  logic acc;
  logic go;
  assign acc = i_psel & i_penable & o_pready;
  assign go = acc & i_pwrite & (i_paddr == H_CTRL) & i_pwdata[C_GO] & ~busy & ~i_pwdata[C_STRAP];

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~(i_paddr inside {H_CTRL, H_ADDR, H_WDATA, H_RDATA, H_STATUS});
      unique case (i_paddr)
        H_CTRL: o_prdata <= {23'h0, ctrl[8:1], 1'b0};
        H_ADDR: o_prdata <= {19'h0, addr};
        H_WDATA: o_prdata <= wdata;
        H_RDATA: o_prdata <= rdata;
        H_STATUS: o_prdata <= {31'h0, busy};
        default: o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ctrl <= RST_CTRL;
      addr <= 13'h0000;
      wdata <= 32'h0000_0000;
    end else if (acc && i_pwrite) begin
      unique case (i_paddr)
        H_CTRL: ctrl <= {i_pwdata[8:1], 1'b0};
        H_ADDR: addr <= i_pwdata[12:0];
        H_WDATA: wdata <= i_pwdata;
        default: ctrl <= ctrl;
      endcase
    end
  end

  // ==========================================================
  // half period divider and input sync
  logic [3:0] div;
  logic tick;
  logic [1:0] io_s;
  assign tick = div == 4'(HALF_CYC - 1);
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      div <= 4'h0;
      io_s <= 2'h0;
    end else begin
      div <= (tick || go) ? 4'h0 : div + 4'h1;
      io_s <= {io_s[0], link.serial_io_stabilizer_pin};
    end
  end

  // ==========================================================
  // bit sequencing
  function automatic logic tx_bit(input logic [5:0] i, input logic [15:0] ins, input logic [31:0] w,
      input logic l);
    logic [5:0] d;
    d = i - 6'd16;
    if (i < 6'd16) begin
      return ins[4'(15 - i)];
    end
    return w[{d[4:3], (l ? d[2:0] : 3'(7 - d[2:0]))}];
  endfunction : tx_bit

  ccsp_host_e state;
  logic [5:0] idx;
  logic [5:0] total;
  logic [15:0] ins;
  logic [5:0] nidx;
  logic [5:0] ridx;
  assign nidx = idx + 6'd1;
  assign ridx = idx - 6'd16;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state <= HS_IDLE;
      busy <= 1'b0;
      idx <= 6'd0;
      total <= 6'd0;
      ins <= 16'h0000;
      rdata <= 32'h0000_0000;
      link.port_select_n <= 1'b1;
      link.shift_clock_format_pin <= 1'b0;
      link.host_sdio_o <= 1'b0;
      link.host_sdio_oe <= 1'b0;
    end else begin
      unique case (state)
        HS_IDLE: begin
          link.port_select_n <= 1'b1;
          link.shift_clock_format_pin <= ctrl[C_STRAP] & ctrl[C_FMT];
          link.host_sdio_o <= ctrl[C_DCS];
          link.host_sdio_oe <= ctrl[C_STRAP];
          if (go) begin
            ins <= {i_pwdata[C_RD], i_pwdata[C_LEN+1:C_LEN], addr};
            total <= 6'd24 + {1'b0, i_pwdata[C_LEN+1:C_LEN], 3'h0};
            idx <= 6'd0;
            busy <= 1'b1;
            link.port_select_n <= 1'b0;
            link.shift_clock_format_pin <= 1'b0;
            link.host_sdio_o <= i_pwdata[C_RD];
            link.host_sdio_oe <= 1'b1;
            state <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (tick) begin
            link.shift_clock_format_pin <= 1'b1;
            if (ins[15] && idx >= 6'd16) begin
              rdata[{ridx[4:3], (ctrl[C_LSB] ? ridx[2:0] : 3'(7 - ridx[2:0]))}] <= io_s[1];
            end
            state <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (tick) begin
            link.shift_clock_format_pin <= 1'b0;
            idx <= nidx;
            if (nidx == total) begin
              state <= HS_END;
            end else if (ctrl[C_PAUSE] && ins[14:13] != LEN_STREAM && nidx >= 6'd16 && nidx[2:0] == 3'h0) begin
              link.port_select_n <= 1'b1;
              link.host_sdio_oe <= ~ins[15];
              state <= HS_GAP;
            end else begin
              link.host_sdio_o <= tx_bit(nidx, ins, wdata, ctrl[C_LSB]);
              link.host_sdio_oe <= ~(ins[15] && nidx >= 6'd16);
              state <= HS_LOW;
            end
          end
        end
        HS_GAP: begin
          if (tick) begin
            link.port_select_n <= 1'b0;
            link.host_sdio_o <= tx_bit(idx, ins, wdata, ctrl[C_LSB]);
            link.host_sdio_oe <= ~ins[15];
            state <= HS_LOW;
          end
        end
        HS_END: begin
          if (tick) begin
            link.port_select_n <= 1'b1;
            link.host_sdio_oe <= 1'b0;
            busy <= 1'b0;
            state <= HS_IDLE;
          end
        end
      endcase
    end
  end
endmodule : ccsp_host

// *** sim/ccsp_checker.sv ***
module ccsp_checker (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic port_select_n,
  input wire logic shift_clock_format_pin,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_o,
  input wire logic dev_sdio_oe
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ==========================================
  // link checks
  reset_idle_a: assert property ($rose(i_rst_n) |-> port_select_n && !host_sdio_oe && !dev_sdio_oe)
    else $error("link not idle after reset");
  start_low_a: assert property ($fell(port_select_n) |-> !shift_clock_format_pin [*4] ##[1:40] shift_clock_format_pin)
    else $error("frame start out of order");
  clk_high_a: assert property ($rose(shift_clock_format_pin) && !port_select_n |->
    shift_clock_format_pin [*8] ##1 !shift_clock_format_pin)
    else $error("shift clock high time wrong");
  idle_clk_a: assert property ($rose(port_select_n) |-> !shift_clock_format_pin)
    else $error("select rose with clock high");
  host_hold_a: assert property ($rose(shift_clock_format_pin) && !port_select_n && host_sdio_oe |->
    $stable(host_sdio_o) [*4])
    else $error("host data moved near clock rise");
  dev_hold_a: assert property ($rose(shift_clock_format_pin) && dev_sdio_oe |-> $stable(dev_sdio_o) [*3])
    else $error("device data moved near clock rise");
  oe_release_a: assert property (port_select_n [*6] |-> !dev_sdio_oe)
    else $error("device drives while deselected");
  oe_gate_a: assert property ($rose(dev_sdio_oe) |-> !port_select_n ##1 (dev_sdio_oe || port_select_n) [*8])
    else $error("device drive outside frame");
  host_turn_a: assert property ($fell(host_sdio_oe) && !port_select_n |-> ##[0:8] dev_sdio_oe)
    else $error("no turnaround after read instruction");
endmodule : ccsp_checker

// *** sim/test_converter_serial_config_port.sv ***
module test_converter_serial_config_port import ccsp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, smode, pdwn, stby, stab, inv;
  logic [1:0] fmt;
  logic [3:0] phase, tmode;
  logic [63:0] cap;
  int n_fail = 0;
  int cmp_count = 0;
  logic [12:0] ra [6] = '{13'h0008, 13'h0008, 13'h0009, 13'h000e, 13'h0014, 13'h000d};
  logic [7:0] rv [6] = '{8'h01, 8'h02, 8'h00, 8'h02, 8'h85, 8'h07};
  logic [13:0] ro [6] = '{14'h2800, 14'h1800, 14'h1000, 14'h1400, 14'h1550, 14'h1557};
  logic [12:0] da [4] = '{OFS_PHASE, OFS_CLOCK, OFS_CFG, OFS_ID};
  logic [7:0] dv [4] = '{RST_PHASE, RST_CLOCK, RST_CFG, CHIP_ID_VAL};
  wire [14:0] outs = {smode, pdwn, stby, stab, fmt, inv, phase, tmode};
  ccsp_if link_if();
  ccsp_device ccsp_device_inst(.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(link_if), .o_serial_mode(smode),
    .o_powerdown(pdwn), .o_standby(stby), .o_stabilizer_en(stab), .o_format_sel(fmt), .o_clock_invert(inv),
    .o_phase_adj(phase), .o_test_mode(tmode));
  ccsp_host ccsp_host_inst(.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(link_if), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr));
  ccsp_checker ccsp_checker_inst(.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .port_select_n(link_if.port_select_n),
    .shift_clock_format_pin(link_if.shift_clock_format_pin), .host_sdio_o(link_if.host_sdio_o),
    .host_sdio_oe(link_if.host_sdio_oe), .dev_sdio_o(link_if.dev_sdio_o), .dev_sdio_oe(link_if.dev_sdio_oe));
  initial forever #5 i_ref_clk = ~i_ref_clk;
  // ==========================================
  // wire capture on shift clock rise
  always @(posedge link_if.shift_clock_format_pin) begin
    if (!link_if.port_select_n) cap <= {cap[62:0], link_if.serial_io_stabilizer_pin};
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge i_ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_ref_clk);
    penable <= 1'b1;
    do @(posedge i_ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic xfer(input logic rd, input logic [1:0] len, input logic [12:0] a, input logic [31:0] d,
    input logic [8:0] x, output logic [31:0] q);
    logic [31:0] s;
    logic e;
    apb(1'b1, H_ADDR, {19'h0, a}, s, e);
    apb(1'b1, H_WDATA, d, s, e);
    apb(1'b1, H_CTRL, {23'h0, x | {5'h00, len, rd, 1'b1}}, s, e);
    s = 32'h0;
    for (int i = 0; i < 20 && s[0] !== 1'b1; i++) apb(1'b0, H_STATUS, 32'h0, s, e);
    while (s[0] !== 1'b0) apb(1'b0, H_STATUS, 32'h0, s, e);
    apb(1'b0, H_RDATA, 32'h0, q, e);
    check({link_if.port_select_n, link_if.shift_clock_format_pin}, 2'h2);
  endtask : xfer
  task automatic do_reset();
    i_rst_n <= 1'b0;
    repeat (10) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
  endtask : do_reset
  initial begin
    #500000;
    n_fail++;
    end_of_test();
  end
  // ==========================================
  // main sequence
  initial begin
    logic [31:0] q;
    logic e;
    do_reset();
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, 2'h0, ra[i], {24'h0, rv[i]}, 9'h000, q);
      check(cap[23:0], {3'h0, ra[i], rv[i]});
      xfer(1'b1, 2'h0, ra[i], 32'h0, 9'h000, q);
      check(q[7:0], rv[i]);
      check(cap[23:0], {3'h4, ra[i], rv[i]});
      check(outs[13:0], ro[i]);
    end
    xfer(1'b0, 2'h3, 13'h000d, 32'h00000305, 9'h000, q);
    check(cap[47:0], {3'h3, 13'h000d, 32'h05030000});
    check({fmt, tmode}, 6'h35);
    xfer(1'b1, 2'h2, 13'h000d, 32'h0, 9'h000, q);
    check(q[23:0], 24'h000305);
    check(cap[39:0], {3'h6, 13'h000d, 24'h050300});
    xfer(1'b0, 2'h1, OFS_PHASE, 32'h00000084, 9'h080, q);
    check({inv, phase}, 5'h14);
    xfer(1'b1, 2'h1, OFS_PHASE, 32'h0, 9'h080, q);
    check(q[15:0], 16'h0084);
    xfer(1'b0, 2'h0, OFS_CFG, 32'h00000042, 9'h000, q);
    xfer(1'b0, 2'h0, OFS_PHASE, 32'h00000013, 9'h100, q);
    check(cap[23:0], {3'h0, OFS_PHASE, 8'hc8});
    xfer(1'b1, 2'h0, OFS_PHASE, 32'h0, 9'h100, q);
    check(q[7:0], 8'h13);
    apb(1'b0, 8'h20, 32'h0, q, e);
    check({e, q}, {1'b1, 32'h0});
    apb(1'b1, 8'h24, 32'h1, q, e);
    check(e, 1'b1);
    do_reset();
    check(outs, 15'h0800);
    apb(1'b1, H_CTRL, 32'h00000030, q, e);
    for (int i = 0; i < 40 && fmt !== 2'h1; i++) @(posedge i_ref_clk);
    check({smode, stab, fmt, link_if.dev_sdio_oe}, 5'h02);
    check(link_if.port_select_n, 1'b1);
    apb(1'b1, H_CTRL, 32'h00000050, q, e);
    for (int i = 0; i < 40 && fmt !== 2'h0; i++) @(posedge i_ref_clk);
    check({smode, stab, fmt}, 4'h4);
    apb(1'b1, H_CTRL, 32'h0, q, e);
    xfer(1'b0, 2'h0, OFS_PHASE, 32'h00000085, 9'h000, q);
    check(inv, 1'b1);
    xfer(1'b0, 2'h0, OFS_CFG, 32'h00000024, 9'h000, q);
    check(outs, 15'h4800);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 2'h0, da[i], 32'h0, 9'h000, q);
      check(q[7:0], dv[i]);
    end
    check({smode, link_if.dev_sdio_oe}, 2'h2);
    end_of_test();
  end
endmodule : test_converter_serial_config_port
